// *** logic/tar_pkg.sv ***
package tar_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_CYCLES = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // Temperatures and setpoints are in 0.1 K steps
  localparam logic [13:0] SP_MAX = 14'h270f;
  localparam logic [13:0] DB_MAX = 14'h03e7;
  localparam logic [2:0] RANGE_MAX = 3'h5;
  localparam logic [2:0] RANGE_RST = 3'h5;
  localparam logic [15:0] KTOP_R5 = 16'h2710;
  localparam logic [15:0] AO_FULL = 16'hffff;

  // Scale = 2^32 / top rounded up, so code = value * 2^16 / top
  // Rounding down would leave exact fractions of the top one code short
  localparam logic [63:0] AO_NUM = 64'h1_0000_0000;
  localparam logic [3:0] SC_DIODE = 4'h6;
  localparam logic [3:0] SC_LOW_OHM = 4'h7;
  localparam logic [3:0] SC_HIGH_OHM = 4'h8;
  localparam logic [31:0] AO_SCALE [9] = '{
    32'((AO_NUM + 64'hc8 - 64'h1) / 64'hc8),
    32'((AO_NUM + 64'h3e8 - 64'h1) / 64'h3e8),
    32'((AO_NUM + 64'h7d0 - 64'h1) / 64'h7d0),
    32'((AO_NUM + 64'hcb2 - 64'h1) / 64'hcb2),
    32'((AO_NUM + 64'h128e - 64'h1) / 64'h128e),
    32'((AO_NUM + 64'h2710 - 64'h1) / 64'h2710),
    32'((AO_NUM + 64'h2710 - 64'h1) / 64'h2710),
    32'((AO_NUM + 64'h2710 - 64'h1) / 64'h2710),
    32'((AO_NUM + 64'h186a0 - 64'h1) / 64'h186a0)
  };

  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_HI_SP = 8'h04;
  localparam logic [7:0] REG_LO_SP = 8'h08;
  localparam logic [7:0] REG_DB = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_AO = 8'h14;

  localparam int CFG_ALM_EN = 0;
  localparam int CFG_LATCH = 1;
  localparam int CFG_UNITS = 2;
  localparam int CFG_AO_CUR = 4;
  localparam int CFG_RANGE = 5;
  localparam int CFG_RLY1 = 8;
  localparam int CFG_RLY2 = 10;

  localparam logic [1:0] PICK_ALARM = 2'h0;
  localparam logic [1:0] PICK_RELAY = 2'h1;
  localparam logic [1:0] PICK_AOUT = 2'h2;
  localparam logic [1:0] PICK_UNITS = 2'h3;

  typedef enum logic [1:0] {RLY_OFF, RLY_ON, RLY_FOLLOW} tar_rly_t;
  typedef enum logic [1:0] {UNIT_K, UNIT_C, UNIT_F, UNIT_SENSOR} tar_unit_t;
  typedef enum logic [2:0] {IN_SI, IN_GAAS, IN_P250, IN_P500, IN_P1000, IN_NTC} tar_in_t;
  typedef enum logic [1:0] {DISP_READING, DISP_HIGH_ALARM_MESSAGE, DISP_LOW_ALARM_MESSAGE} tar_disp_t;
  typedef enum logic [3:0] {
    MS_NORMAL, MS_PICK, MS_ALM_EN, MS_ALM_HI, MS_ALM_LO, MS_ALM_DB, MS_LATCH_SETTING_PROMPT,
    MS_RLY1, MS_RLY2, MS_AO_MODE, MS_AO_RANGE, MS_UNITS
  } tar_menu_t;
endpackage : tar_pkg

// *** logic/tar_ao_scale.sv ***
`timescale 1ns/1ps
`default_nettype none
module tar_ao_scale (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [19:0] value,
  input wire logic [31:0] scale,
  output logic [15:0] code
);
  logic [51:0] prod;

  assign prod = {32'h0, value} * {20'h0, scale};

  // Unsigned input already floors at zero; only the top needs a clamp
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      code <= 16'h0;
    end else if (|prod[51:32]) begin
      code <= tar_pkg::AO_FULL;
    end else begin
      code <= prod[31:16];
    end
  end
endmodule : tar_ao_scale
`default_nettype wire

// *** logic/tar_top.sv ***
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tar_top #(
  parameter int unsigned BLINK_CYC = tar_pkg::BLINK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reading_k,
  input wire logic [19:0] reading_sensor,
  input wire logic over_curve_hi,
  input wire logic over_curve_lo,
  input wire logic curve_none,
  input wire logic [2:0] input_type,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_enter,
  input wire logic key_select,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic high_alarm,
  output logic low_alarm,
  output logic relay1,
  output logic relay2,
  output logic ao_current_mode,
  output logic [15:0] ao_code,
  output var tar_pkg::tar_disp_t disp_sel,
  output logic [3:0] unit_lamp,
  output var tar_pkg::tar_menu_t menu_state,
  output logic [13:0] edit_value
);
  logic rst_q1;
  logic rst_n_s;
  logic alm_en_r;
  logic latch_en_r;
  tar_pkg::tar_unit_t units_r;
  logic ao_cur_r;
  logic [2:0] ao_range_r;
  tar_pkg::tar_rly_t rly1_r;
  tar_pkg::tar_rly_t rly2_r;
  logic [13:0] hi_sp_r;
  logic [13:0] lo_sp_r;
  logic [13:0] db_r;
  logic alm_hi_r;
  logic alm_lo_r;
  logic run;
  logic [15:0] hi_ext;
  logic [15:0] lo_ext;
  logic [15:0] db_ext;
  logic [15:0] hi_rel;
  logic [15:0] lo_rel;
  logic hi_cond;
  logic lo_cond;
  logic hi_ok;
  logic lo_ok;
  logic [31:0] blink_cnt_r;
  logic blink_ph_r;
  tar_pkg::tar_menu_t state_r;
  tar_pkg::tar_menu_t state_nxt;
  logic [13:0] edit_r;
  logic commit;
  logic [3:0] sc_idx;
  logic [19:0] ao_val;
  logic [1:0] lamp_sel;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n_s <= rst_q1;
    end
  end

  function automatic logic [13:0] clamp14(input logic [15:0] v, input logic [13:0] mx);
    clamp14 = (v > {2'h0, mx}) ? mx : v[13:0];
  endfunction : clamp14

  function automatic logic rly_drive(input tar_pkg::tar_rly_t m, input logic a);
    unique case (m)
      tar_pkg::RLY_OFF: rly_drive = 1'b0;
      tar_pkg::RLY_ON: rly_drive = 1'b1;
      tar_pkg::RLY_FOLLOW: rly_drive = a;
      default: rly_drive = 1'b0;
    endcase
  endfunction : rly_drive

  // Alarm comparison, all in Kelvin tenths whatever the display unit
  assign run = alm_en_r && !curve_none;
  assign hi_ext = {2'h0, hi_sp_r};
  assign lo_ext = {2'h0, lo_sp_r};
  assign db_ext = {2'h0, db_r};
  assign hi_rel = (hi_ext >= db_ext) ? hi_ext - db_ext : 16'h0;
  assign lo_rel = lo_ext + db_ext;
  assign hi_cond = (reading_k > hi_ext) || over_curve_hi;
  assign lo_cond = (reading_k < lo_ext) || over_curve_lo;
  assign hi_ok = !over_curve_hi && (reading_k <= hi_rel);
  assign lo_ok = !over_curve_lo && (reading_k >= lo_rel);

  // Set beats clear, so a select in the same cycle as a new trip is lost
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      alm_hi_r <= 1'b0;
      alm_lo_r <= 1'b0;
    end else if (!run) begin
      alm_hi_r <= 1'b0;
      alm_lo_r <= 1'b0;
    end else begin
      if (hi_cond) begin
        alm_hi_r <= 1'b1;
      end else if (latch_en_r ? key_select : hi_ok) begin
        alm_hi_r <= 1'b0;
      end
      if (lo_cond) begin
        alm_lo_r <= 1'b1;
      end else if (latch_en_r ? key_select : lo_ok) begin
        alm_lo_r <= 1'b0;
      end
    end
  end

  assign high_alarm = alm_hi_r;
  assign low_alarm = alm_lo_r;

  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      relay1 <= 1'b0;
      relay2 <= 1'b0;
    end else begin
      relay1 <= rly_drive(rly1_r, alm_lo_r);
      relay2 <= rly_drive(rly2_r, alm_hi_r);
    end
  end

  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      blink_cnt_r <= 32'h0;
      blink_ph_r <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYC - 1) begin
      blink_cnt_r <= 32'h0;
      blink_ph_r <= !blink_ph_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // High message wins when both alarms are up
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      disp_sel <= tar_pkg::DISP_READING;
    end else if (blink_ph_r && alm_hi_r) begin
      disp_sel <= tar_pkg::DISP_HIGH_ALARM_MESSAGE;
    end else if (blink_ph_r && alm_lo_r) begin
      disp_sel <= tar_pkg::DISP_LOW_ALARM_MESSAGE;
    end else begin
      disp_sel <= tar_pkg::DISP_READING;
    end
  end

  // Keypad menus
  function automatic logic [13:0] edit_max(input tar_pkg::tar_menu_t s);
    unique case (s)
      tar_pkg::MS_PICK, tar_pkg::MS_UNITS: edit_max = 14'h3;
      tar_pkg::MS_ALM_HI, tar_pkg::MS_ALM_LO: edit_max = tar_pkg::SP_MAX;
      tar_pkg::MS_ALM_DB: edit_max = tar_pkg::DB_MAX;
      tar_pkg::MS_RLY1, tar_pkg::MS_RLY2: edit_max = 14'h2;
      tar_pkg::MS_AO_RANGE: edit_max = {11'h0, tar_pkg::RANGE_MAX};
      tar_pkg::MS_NORMAL: edit_max = 14'h0;
      default: edit_max = 14'h1;
    endcase
  endfunction : edit_max

  function automatic logic [13:0] edit_load(input tar_pkg::tar_menu_t s);
    unique case (s)
      tar_pkg::MS_ALM_EN: edit_load = {13'h0, alm_en_r};
      tar_pkg::MS_ALM_HI: edit_load = hi_sp_r;
      tar_pkg::MS_ALM_LO: edit_load = lo_sp_r;
      tar_pkg::MS_ALM_DB: edit_load = db_r;
      tar_pkg::MS_LATCH_SETTING_PROMPT: edit_load = {13'h0, latch_en_r};
      tar_pkg::MS_RLY1: edit_load = {12'h0, rly1_r};
      tar_pkg::MS_RLY2: edit_load = {12'h0, rly2_r};
      tar_pkg::MS_AO_MODE: edit_load = {13'h0, ao_cur_r};
      tar_pkg::MS_AO_RANGE: edit_load = {11'h0, ao_range_r};
      tar_pkg::MS_UNITS: edit_load = {12'h0, units_r};
      default: edit_load = 14'h0;
    endcase
  endfunction : edit_load

  always_comb begin
    state_nxt = state_r;
    if (key_select) begin
      state_nxt = (state_r == tar_pkg::MS_NORMAL) ? tar_pkg::MS_PICK : tar_pkg::MS_NORMAL;
    end else if (key_enter) begin
      unique case (state_r)
        tar_pkg::MS_NORMAL: state_nxt = tar_pkg::MS_NORMAL;
        tar_pkg::MS_PICK: begin
          unique case (edit_r[1:0])
            tar_pkg::PICK_ALARM: state_nxt = tar_pkg::MS_ALM_EN;
            tar_pkg::PICK_RELAY: state_nxt = tar_pkg::MS_RLY1;
            tar_pkg::PICK_AOUT: state_nxt = tar_pkg::MS_AO_MODE;
            tar_pkg::PICK_UNITS: state_nxt = tar_pkg::MS_UNITS;
          endcase
        end
        tar_pkg::MS_ALM_EN: state_nxt = edit_r[0] ? tar_pkg::MS_ALM_HI : tar_pkg::MS_NORMAL;
        tar_pkg::MS_ALM_HI: state_nxt = tar_pkg::MS_ALM_LO;
        tar_pkg::MS_ALM_LO: state_nxt = tar_pkg::MS_ALM_DB;
        tar_pkg::MS_ALM_DB: state_nxt = tar_pkg::MS_LATCH_SETTING_PROMPT;
        tar_pkg::MS_LATCH_SETTING_PROMPT: state_nxt = tar_pkg::MS_NORMAL;
        tar_pkg::MS_RLY1: state_nxt = tar_pkg::MS_RLY2;
        tar_pkg::MS_RLY2: state_nxt = tar_pkg::MS_NORMAL;
        tar_pkg::MS_AO_MODE: state_nxt = tar_pkg::MS_AO_RANGE;
        tar_pkg::MS_AO_RANGE: state_nxt = tar_pkg::MS_NORMAL;
        tar_pkg::MS_UNITS: state_nxt = tar_pkg::MS_NORMAL;
        default: state_nxt = tar_pkg::MS_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= tar_pkg::MS_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Numbers clamp at their limits, selection lists wrap around
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      edit_r <= 14'h0;
    end else if (state_nxt != state_r) begin
      edit_r <= edit_load(state_nxt);
    end else if (key_up) begin
      if (edit_r < edit_max(state_r)) begin
        edit_r <= edit_r + 14'h1;
      end else if (state_r < tar_pkg::MS_ALM_HI || state_r > tar_pkg::MS_ALM_DB) begin
        edit_r <= 14'h0;
      end
    end else if (key_down) begin
      if (edit_r != 14'h0) begin
        edit_r <= edit_r - 14'h1;
      end else if (state_r < tar_pkg::MS_ALM_HI || state_r > tar_pkg::MS_ALM_DB) begin
        edit_r <= edit_max(state_r);
      end
    end
  end

  assign commit = key_enter && !key_select;
  assign menu_state = state_r;
  assign edit_value = edit_r;

  // Configuration; a bus write in the same cycle as a keypad store wins
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      alm_en_r <= 1'b0;
      latch_en_r <= 1'b0;
      units_r <= tar_pkg::UNIT_K;
      ao_cur_r <= 1'b0;
      ao_range_r <= tar_pkg::RANGE_RST;
      rly1_r <= tar_pkg::RLY_OFF;
      rly2_r <= tar_pkg::RLY_OFF;
      hi_sp_r <= 14'h0;
      lo_sp_r <= 14'h0;
      db_r <= 14'h0;
    end else begin
      if (commit) begin
        unique case (state_r)
          tar_pkg::MS_ALM_EN: alm_en_r <= edit_r[0];
          tar_pkg::MS_ALM_HI: hi_sp_r <= edit_r;
          tar_pkg::MS_ALM_LO: lo_sp_r <= edit_r;
          tar_pkg::MS_ALM_DB: db_r <= edit_r;
          tar_pkg::MS_LATCH_SETTING_PROMPT: latch_en_r <= edit_r[0];
          tar_pkg::MS_RLY1: rly1_r <= tar_pkg::tar_rly_t'(edit_r[1:0]);
          tar_pkg::MS_RLY2: rly2_r <= tar_pkg::tar_rly_t'(edit_r[1:0]);
          tar_pkg::MS_AO_MODE: ao_cur_r <= edit_r[0];
          tar_pkg::MS_AO_RANGE: ao_range_r <= edit_r[2:0];
          tar_pkg::MS_UNITS: units_r <= tar_pkg::tar_unit_t'(edit_r[1:0]);
          default: ;
        endcase
      end
      if (wr) begin
        unique case (addr)
          tar_pkg::REG_CFG: begin
            alm_en_r <= wdata[tar_pkg::CFG_ALM_EN];
            latch_en_r <= wdata[tar_pkg::CFG_LATCH];
            units_r <= tar_pkg::tar_unit_t'(wdata[tar_pkg::CFG_UNITS +: 2]);
            ao_cur_r <= wdata[tar_pkg::CFG_AO_CUR];
            ao_range_r <= (wdata[tar_pkg::CFG_RANGE +: 3] > tar_pkg::RANGE_MAX) ?
                          tar_pkg::RANGE_MAX : wdata[tar_pkg::CFG_RANGE +: 3];
            rly1_r <= tar_pkg::tar_rly_t'(wdata[tar_pkg::CFG_RLY1 +: 2]);
            rly2_r <= tar_pkg::tar_rly_t'(wdata[tar_pkg::CFG_RLY2 +: 2]);
          end
          tar_pkg::REG_HI_SP: hi_sp_r <= clamp14(wdata[15:0], tar_pkg::SP_MAX);
          tar_pkg::REG_LO_SP: lo_sp_r <= clamp14(wdata[15:0], tar_pkg::SP_MAX);
          tar_pkg::REG_DB: db_r <= clamp14(wdata[15:0], tar_pkg::DB_MAX);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rdata <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        tar_pkg::REG_CFG: rdata <= {20'h0, rly2_r, rly1_r, ao_range_r, ao_cur_r, units_r, latch_en_r, alm_en_r};
        tar_pkg::REG_HI_SP: rdata <= {18'h0, hi_sp_r};
        tar_pkg::REG_LO_SP: rdata <= {18'h0, lo_sp_r};
        tar_pkg::REG_DB: rdata <= {18'h0, db_r};
        tar_pkg::REG_STAT: rdata <= {22'h0, state_r, disp_sel, relay2, relay1, alm_lo_r, alm_hi_r};
        tar_pkg::REG_AO: rdata <= {16'h0, ao_code};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  assign lamp_sel = (state_r == tar_pkg::MS_UNITS) ? edit_r[1:0] : units_r;

  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      unit_lamp <= 4'h1;
    end else begin
      unit_lamp <= 4'h1 << lamp_sel;
    end
  end

  // Analog output; same 16-bit code drives either output stage
  always_comb begin
    if (!curve_none) begin
      sc_idx = {1'b0, ao_range_r};
      ao_val = {4'h0, reading_k};
    end else begin
      ao_val = reading_sensor;
      unique case (input_type)
        tar_pkg::IN_SI, tar_pkg::IN_GAAS: sc_idx = tar_pkg::SC_DIODE;
        tar_pkg::IN_P250, tar_pkg::IN_P500: sc_idx = tar_pkg::SC_LOW_OHM;
        default: sc_idx = tar_pkg::SC_HIGH_OHM;
      endcase
    end
  end

  tar_ao_scale u_scale (
    .clock(clock),
    .rst_n(rst_n_s),
    .value(ao_val),
    .scale(tar_pkg::AO_SCALE[sc_idx]),
    .code(ao_code)
  );

  assign ao_current_mode = ao_cur_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_s);

  property p_hi_set;
    run && hi_cond |=> alm_hi_r;
  endproperty
  a_hi_set: assert property (p_hi_set) else $error("high alarm not raised");
  property p_lo_set;
    run && lo_cond |=> alm_lo_r;
  endproperty
  a_lo_set: assert property (p_lo_set) else $error("low alarm not raised");
  property p_no_curve;
    curve_none |=> !alm_hi_r && !alm_lo_r;
  endproperty
  a_no_curve: assert property (p_no_curve) else $error("alarm without curve");
  property p_master_off;
    !alm_en_r |=> !alm_hi_r && !alm_lo_r;
  endproperty
  a_master_off: assert property (p_master_off) else $error("alarm while disabled");
  property p_latch_hold;
    run && latch_en_r && alm_hi_r && !key_select |=> alm_hi_r;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped");
  property p_hi_clear;
    run && !latch_en_r && alm_hi_r && hi_ok |=> !alm_hi_r;
  endproperty
  a_hi_clear: assert property (p_hi_clear) else $error("high alarm not cleared");
  property p_lo_clear;
    run && !latch_en_r && alm_lo_r && lo_ok && !lo_cond |=> !alm_lo_r;
  endproperty
  a_lo_clear: assert property (p_lo_clear) else $error("low alarm not cleared");
  property p_relay_follow;
    rly1_r == tar_pkg::RLY_FOLLOW && rly2_r == tar_pkg::RLY_FOLLOW |=>
      relay1 == $past(alm_lo_r) && relay2 == $past(alm_hi_r);
  endproperty
  a_relay_follow: assert property (p_relay_follow) else $error("relay not following");
  property p_relay_on;
    rly2_r == tar_pkg::RLY_ON ##1 rly2_r == tar_pkg::RLY_ON |=> relay2;
  endproperty
  a_relay_on: assert property (p_relay_on) else $error("forced relay off");
  property p_limits;
    hi_sp_r <= tar_pkg::SP_MAX && lo_sp_r <= tar_pkg::SP_MAX && db_r <= tar_pkg::DB_MAX;
  endproperty
  a_limits: assert property (p_limits) else $error("setting out of range");
  property p_seq;
    state_r == tar_pkg::MS_ALM_LO && key_enter && !key_select |=> state_r == tar_pkg::MS_ALM_DB;
  endproperty
  a_seq: assert property (p_seq) else $error("alarm setup order broken");
  property p_disp;
    blink_ph_r && alm_hi_r |=> disp_sel == tar_pkg::DISP_HIGH_ALARM_MESSAGE;
  endproperty
  a_disp: assert property (p_disp) else $error("alarm message missing");
  property p_ao_clamp;
    !curve_none && ao_range_r == tar_pkg::RANGE_MAX && reading_k > tar_pkg::KTOP_R5 |=> ao_code == tar_pkg::AO_FULL;
  endproperty
  a_ao_clamp: assert property (p_ao_clamp) else $error("output not clamped");

  c_hi_alarm: cover property ($rose(alm_hi_r));
  c_relay1_on: cover property (rly1_r == tar_pkg::RLY_FOLLOW && $rose(relay1));
  c_latch_menu: cover property (state_r == tar_pkg::MS_LATCH_SETTING_PROMPT && key_enter);
endmodule : tar_top
`default_nettype wire

// *** testbench/tar_recorder.sv ***
`timescale 1ns/1ps
`default_nettype none
module tar_recorder (
  input wire logic clock,
  input wire logic current_mode,
  input wire logic [15:0] code,
  output logic [15:0] level
);
  // Logger input: mV in voltage mode, uA in current mode
  // Truncating division, so zero, mid and full scale are exact
  always_ff @(posedge clock) begin
    if (current_mode) begin
      level <= 16'(32'h0fa0 + (32'(code) * 32'h3e80) / 32'hffff);
    end else begin
      level <= 16'((32'(code) * 32'h2710) / 32'hffff);
    end
  end
endmodule : tar_recorder
`default_nettype wire

// *** testbench/temperature_alarm_relay_output_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module temperature_alarm_relay_output_test;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reading_k = 16'h0000;
  logic [19:0] reading_sensor = 20'h00000;
  logic over_hi = 1'b0;
  logic over_lo = 1'b0;
  logic curve_none = 1'b0;
  logic [2:0] input_type = 3'h0;
  logic [3:0] keys = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic high_alarm, low_alarm, relay1, relay2, ao_cur;
  logic [15:0] ao_code;
  logic [15:0] level;
  tar_pkg::tar_disp_t disp_sel;
  tar_pkg::tar_menu_t menu_state;
  logic [3:0] unit_lamp;
  logic [13:0] edit_value;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  // Short blink phase keeps the display test brief
  tar_top #(.BLINK_CYC(4)) u_dut (.clock(clock), .rstn(rstn), .reading_k(reading_k),
    .reading_sensor(reading_sensor), .over_curve_hi(over_hi), .over_curve_lo(over_lo),
    .curve_none(curve_none), .input_type(input_type), .key_up(keys[0]), .key_down(keys[1]),
    .key_enter(keys[2]), .key_select(keys[3]), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .high_alarm(high_alarm), .low_alarm(low_alarm), .relay1(relay1),
    .relay2(relay2), .ao_current_mode(ao_cur), .ao_code(ao_code), .disp_sel(disp_sel),
    .unit_lamp(unit_lamp), .menu_state(menu_state), .edit_value(edit_value));

  tar_recorder u_rec (.clock(clock), .current_mode(ao_cur), .code(ao_code), .level(level));

  task automatic conclude();
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic press(input int k, input tar_pkg::tar_menu_t m);
    @(posedge clock);
    keys[k] <= 1'b1;
    @(posedge clock);
    keys <= 4'h0;
    #1 chk(32'(menu_state), 32'(m), "menu step");
  endtask : press

  task automatic set_k(input logic [15:0] v);
    @(posedge clock);
    reading_k <= v;
    tick(4);
  endtask : set_k

  task automatic alm(input logic h, input logic l, input logic r1, input logic r2);
    chk({28'h0, high_alarm, low_alarm, relay1, relay2}, {28'h0, h, l, r1, r2}, "alarm/relay");
  endtask : alm

  task automatic blink(input tar_pkg::tar_disp_t msg);
    logic [1:0] seen;
    seen = 2'b00;
    repeat (16) begin
      tick(1);
      seen[0] = seen[0] | (disp_sel === tar_pkg::DISP_READING);
      seen[1] = seen[1] | (disp_sel === msg);
    end
    chk(32'(seen), 32'h3, "display alternation");
  endtask : blink

  task automatic t_regs();
    rreg(tar_pkg::REG_CFG, rv);
    chk(rv, 32'h0000_00a0, "cfg defaults");
    rreg(8'h20, rv);
    chk(rv, 32'h0, "unmapped read");
    wreg(tar_pkg::REG_HI_SP, 32'hffff);
    wreg(tar_pkg::REG_DB, 32'h1000);
    rreg(tar_pkg::REG_HI_SP, rv);
    chk(rv, 32'h270f, "setpoint ceiling");
    rreg(tar_pkg::REG_DB, rv);
    chk(rv, 32'h3e7, "deadband ceiling");
  endtask : t_regs

  task automatic t_menu();
    press(3, tar_pkg::MS_PICK);
    press(2, tar_pkg::MS_ALM_EN);
    press(2, tar_pkg::MS_NORMAL);
    press(3, tar_pkg::MS_PICK);
    press(2, tar_pkg::MS_ALM_EN);
    press(0, tar_pkg::MS_ALM_EN);
    press(2, tar_pkg::MS_ALM_HI);
    chk(32'(edit_value), 32'h270f, "high setpoint loaded");
    press(0, tar_pkg::MS_ALM_HI);
    chk(32'(edit_value), 32'h270f, "setpoint edit ceiling");
    press(2, tar_pkg::MS_ALM_LO);
    press(2, tar_pkg::MS_ALM_DB);
    press(2, tar_pkg::MS_LATCH_SETTING_PROMPT);
    press(2, tar_pkg::MS_NORMAL);
    rreg(tar_pkg::REG_CFG, rv);
    chk(32'(rv[0]), 32'h1, "enable stored");
    press(3, tar_pkg::MS_PICK);
    press(0, tar_pkg::MS_PICK);
    press(2, tar_pkg::MS_RLY1);
    press(0, tar_pkg::MS_RLY1);
    press(2, tar_pkg::MS_RLY2);
    press(2, tar_pkg::MS_NORMAL);
    alm(0, 0, 1, 0);
    press(3, tar_pkg::MS_PICK);
    press(1, tar_pkg::MS_PICK);
    press(2, tar_pkg::MS_UNITS);
    press(0, tar_pkg::MS_UNITS);
    tick(1);
    chk(32'(unit_lamp), 32'h2, "lamp follows edit");
    press(2, tar_pkg::MS_NORMAL);
    rreg(tar_pkg::REG_CFG, rv);
    chk(32'(rv[3:2]), 32'h1, "units stored");
    press(3, tar_pkg::MS_PICK);
    press(0, tar_pkg::MS_PICK);
    press(0, tar_pkg::MS_PICK);
    press(2, tar_pkg::MS_AO_MODE);
    press(2, tar_pkg::MS_AO_RANGE);
    press(2, tar_pkg::MS_NORMAL);
  endtask : t_menu

  task automatic t_alarm();
    wreg(tar_pkg::REG_HI_SP, 32'h3e8);
    wreg(tar_pkg::REG_LO_SP, 32'h64);
    wreg(tar_pkg::REG_DB, 32'ha);
    wreg(tar_pkg::REG_CFG, 32'haa0);
    set_k(16'h3e9);
    alm(0, 0, 0, 0);
    wreg(tar_pkg::REG_CFG, 32'haa1);
    tick(4);
    alm(1, 0, 0, 1);
    rreg(tar_pkg::REG_STAT, rv);
    chk(rv & 32'hf, 32'h9, "status alarm bits");
    blink(tar_pkg::DISP_HIGH_ALARM_MESSAGE);
    wreg(tar_pkg::REG_CFG, 32'haa5);
    tick(4);
    chk(32'(unit_lamp), 32'h2, "unit lamp");
    alm(1, 0, 0, 1);
    set_k(16'h3e3);
    alm(1, 0, 0, 1);
    set_k(16'h3de);
    alm(0, 0, 0, 0);
    set_k(16'h63);
    alm(0, 1, 1, 0);
    blink(tar_pkg::DISP_LOW_ALARM_MESSAGE);
    set_k(16'h6d);
    alm(0, 1, 1, 0);
    set_k(16'h6e);
    alm(0, 0, 0, 0);
    @(posedge clock);
    over_hi <= 1'b1;
    tick(4);
    alm(1, 0, 0, 1);
    @(posedge clock);
    over_hi <= 1'b0;
    over_lo <= 1'b1;
    tick(4);
    alm(0, 1, 1, 0);
    @(posedge clock);
    over_lo <= 1'b0;
    curve_none <= 1'b1;
    set_k(16'h3e9);
    alm(0, 0, 0, 0);
    @(posedge clock);
    curve_none <= 1'b0;
    wreg(tar_pkg::REG_CFG, 32'h1a1);
    set_k(16'h1f4);
    alm(0, 0, 1, 0);
    wreg(tar_pkg::REG_CFG, 32'haa3);
    set_k(16'h3e9);
    set_k(16'h1f4);
    alm(1, 0, 0, 1);
    press(3, tar_pkg::MS_PICK);
    tick(3);
    alm(0, 0, 0, 0);
    press(3, tar_pkg::MS_NORMAL);
  endtask : t_alarm

  task automatic t_aout();
    logic [15:0] tops [6];
    tops = '{16'h00c8, 16'h03e8, 16'h07d0, 16'h0cb2, 16'h128e, 16'h2710};
    for (int r = 0; r < 6; r++) begin
      wreg(tar_pkg::REG_CFG, (32'(r) << 5) | 32'h8);
      set_k(tops[r] >> 1);
      chk(32'(ao_code), 32'h8000, "range mid code");
      chk(32'(level), 32'h1388, "mid volts");
    end
    set_k(16'h2711);
    chk(32'(ao_code), 32'hffff, "clamp high");
    rreg(tar_pkg::REG_AO, rv);
    chk(rv, 32'hffff, "code register");
    set_k(16'h0000);
    chk(32'(ao_code), 32'h0, "zero code");
    wreg(tar_pkg::REG_CFG, 32'hb0);
    set_k(16'h1388);
    chk(32'(level), 32'h2ee0, "mid current");
    @(posedge clock);
    curve_none <= 1'b1;
    for (int t = 0; t < 6; t++) begin
      @(posedge clock);
      input_type <= 3'(t);
      reading_sensor <= (t < 4) ? 20'h01388 : 20'h0c350;
      tick(4);
      chk(32'(ao_code), 32'h8000, "sensor scale");
    end
  endtask : t_aout

  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    tick(3);
    t_regs();
    t_menu();
    t_alarm();
    t_aout();
    conclude();
  end
endmodule : temperature_alarm_relay_output_test
`default_nettype wire
